// ---- verilog/dac_host_pkg.sv ----
// shared constants of the dac serial host interface
`default_nettype none
package dac_host_pkg;
  // command word geometry
  localparam int WORD_BITS = 24;
  localparam int DATA_BITS = 14;
  localparam int CHAN_BITS = 5;
  localparam int TGT_BITS = 2;
  localparam int HDR_BITS = 10;
  localparam int IDX_BITS = 1 + CHAN_BITS + TGT_BITS;
  // field positions inside the command word
  localparam int POS_BANK = 23;
  localparam int POS_RW = 22;
  localparam int POS_CHAN = 16;
  localparam int POS_TGT = 14;
  // bits per standalone frame
  localparam logic [4:0] CNT_FULL = 5'h18;
  // two-wire framing
  localparam logic [4:0] TW_ADDR_FIXED = 5'h15;
  localparam int TW_TGT_POS = 6;
  localparam logic [1:0] TW_LAST_BYTE = 2'h3;
  localparam logic [3:0] TW_BYTE_BITS = 4'h8;
  // bus speed against the sampling clock
  localparam int CLK_KHZ = 100000;
  localparam int TW_MAX_KHZ = 400;
  localparam int TW_HALF_CYC = CLK_KHZ / (2 * TW_MAX_KHZ);
  // reset image of the synchronised pins
  localparam int SYNC_BITS = 13;
  localparam logic [SYNC_BITS-1:0] SYNC_RST = 13'h00ec;
endpackage
`default_nettype wire

// ---- verilog/dac_cmd_if.sv ----
// channel update carrier from the two-wire receiver to the host interface
`default_nettype none
interface dac_cmd_if
  import dac_host_pkg::*;
();
  logic valid;
  logic bank;
  logic [CHAN_BITS-1:0] chan;
  logic [TGT_BITS-1:0] tgt;
  logic [DATA_BITS-1:0] data;
  modport src (output valid, bank, chan, tgt, data);
  modport dst (input valid, bank, chan, tgt, data);
endinterface
`default_nettype wire

// ---- verilog/pin_sync.sv ----
// two-flop synchroniser for asynchronous pin levels
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage is read by the second only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule
`default_nettype wire

// ---- verilog/twowire_slave.sv ----
// two-wire receive-only slave with four-byte write framing
`default_nettype none
module twowire_slave
  import dac_host_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // enable and address straps
  input wire logic en_i,
  input wire logic [1:0] strap_i,
  // synchronised bus levels
  input wire logic scl_i,
  input wire logic sda_i,
  output logic ack_oe_o,
  // decoded channel update
  dac_cmd_if.src cmd
);
  typedef enum logic [1:0] {TW_IDLE, TW_RECV, TW_ACK, TW_WAIT} tw_state_t;
  tw_state_t state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic oe_r;
  logic valid_r;
  logic [3:0] bits_r;
  logic [1:0] idx_r;
  logic [7:0] byte_r;
  logic [7:0] ptr_r;
  logic [7:0] msb_r;

  wire scl_rise = ~scl_q_r & scl_i;
  wire scl_fall = scl_q_r & ~scl_i;
  wire start_c = scl_q_r & scl_i & sda_q_r & ~sda_i;
  wire stop_c = scl_q_r & scl_i & ~sda_q_r & sda_i;
  wire byte_done = (bits_r == TW_BYTE_BITS);
  wire addr_hit = (byte_r[7:1] == {TW_ADDR_FIXED, strap_i}) & ~byte_r[0];
  wire take = (idx_r != 2'h0) | addr_hit;

  // bus state machine
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= TW_IDLE;
      bits_r <= '0;
      idx_r <= '0;
      byte_r <= '0;
      ptr_r <= '0;
      msb_r <= '0;
      oe_r <= 1'b0;
      valid_r <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      valid_r <= 1'b0;
      if (!en_i || stop_c) begin
        state_r <= TW_IDLE;
        oe_r <= 1'b0;
      end else if (start_c) begin
        state_r <= TW_RECV;
        bits_r <= '0;
        idx_r <= '0;
        oe_r <= 1'b0;
      end else begin
        case (state_r)
          TW_RECV: begin
            if (scl_rise && !byte_done) begin
              byte_r <= {byte_r[6:0], sda_i};
              bits_r <= bits_r + 4'h1;
            end
            if (scl_fall && byte_done) begin
              state_r <= take ? TW_ACK : TW_WAIT;
              oe_r <= take;
            end
          end
          TW_ACK: if (scl_fall) begin
            oe_r <= 1'b0;
            bits_r <= '0;
            idx_r <= idx_r + 2'h1;
            if (idx_r == 2'h1) ptr_r <= byte_r;
            if (idx_r == 2'h2) msb_r <= byte_r;
            valid_r <= (idx_r == TW_LAST_BYTE);
            state_r <= (idx_r == TW_LAST_BYTE) ? TW_WAIT : TW_RECV;
          end
          default: ;
        endcase
      end
    end
  end

  assign ack_oe_o = oe_r;
  assign cmd.valid = valid_r;
  assign cmd.bank = 1'b0;
  assign cmd.chan = ptr_r[CHAN_BITS-1:0];
  assign cmd.tgt = msb_r[TW_TGT_POS +: TGT_BITS];
  assign cmd.data = {msb_r[TW_TGT_POS-1:0], byte_r};

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_ack_drive: assert property (
    state_r == TW_RECV && scl_fall && byte_done && take && en_i
      && !start_c && !stop_c |=> ack_oe_o && state_r == TW_ACK)
    else $error("acknowledge not driven after byte");
  chk_addr_miss: assert property (
    state_r == TW_RECV && idx_r == 2'h0 && scl_fall && byte_done
      && !addr_hit |=> !ack_oe_o)
    else $error("foreign address acknowledged");
  chk_commit_last: assert property (
    valid_r |-> $past(idx_r) == TW_LAST_BYTE && !ack_oe_o)
    else $error("update before fourth byte");
endmodule
`default_nettype wire

// ---- verilog/dac_serial_host_interface.sv ----
// serial host interface of a 32-channel dac: framed link and two-wire
// Summary of operation
// - command word: bank, read flag, channel, target, 14-bit data
// - standalone mode works with continuous or gated shift clock
// - frame sync fall starts a cycle and clears the bit counter
// - standalone ignores non-falling sync edges until 24 bits, then shift clock
// - chain mode shifts while sync low; extra bits leave on chain output
// - chain output changes on rising shift edge, valid at falling edge
// - in chain mode, sync rise latches the word and stops further shifting
// - in chain mode, sync rise before 24 clocks marks a bad frame, data dropped
// - read flag set selects a register by channel and target
// - next frame returns register in low 14 bits, address in top 10
// - first readback bit appears at the falling sync edge
// - slave address has five fixed bits and two strap bits
// - two-wire transfers work at bus clocks up to 400 kHz
// - device pulls data low in ninth period after its bytes
// - two-wire is write only; idle waits for start and own address
// - address, pointer, two data bytes update one channel at the fourth acknowledge, before stop
// - busy low disables host interfaces and ignores load strobes
// - most significant bit first; framed link samples falling, shifts out rising (two-wire samples on rising bus clock)
`default_nettype none
module dac_serial_host_interface
  import dac_host_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // mode pins and device status
  input wire logic interface_select_pin_i,
  input wire logic protocol_select_i,
  input wire logic chain_enable_i,
  input wire logic toggle_enable_i,
  input wire logic device_busy_n_i,
  input wire logic load_strobe_n_i,
  // framed serial link
  input wire logic frame_sync_n_i,
  input wire logic shift_clk_i,
  input wire logic data_in_i,
  output logic chain_data_out_o,
  // two-wire link
  input wire logic bus_clk_i,
  input wire logic bus_data_i,
  output logic bus_data_o,
  output logic bus_data_oe_o,
  input wire logic slave_addr_strap_hi_i,
  input wire logic slave_addr_strap_lo_i,
  // register updates towards the dac core
  output logic upd_valid_o,
  output logic upd_bank_o,
  output logic [CHAN_BITS-1:0] upd_channel_address_o,
  output logic [TGT_BITS-1:0] upd_target_o,
  output logic [DATA_BITS-1:0] upd_data_field_o,
  // events
  output logic load_pulse_o,
  output logic bad_frame_o
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_BITS-1:0] sync_q;
  logic iface_s;
  logic proto_s;
  logic chain_s;
  logic toggle_s;
  logic busy_n_s;
  logic load_n_s;
  logic fs_n_s;
  logic sck_s;
  logic din_s;
  logic scl_s;
  logic sda_s;
  logic [1:0] strap_s;

  pin_sync #(
    .WIDTH(SYNC_BITS),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({interface_select_pin_i, protocol_select_i, chain_enable_i,
              toggle_enable_i, device_busy_n_i, load_strobe_n_i,
              frame_sync_n_i, shift_clk_i, data_in_i, bus_clk_i,
              bus_data_i, slave_addr_strap_hi_i,
              slave_addr_strap_lo_i}),
    .sync_o(sync_q)
  );

  // unpack the synchronised levels
  assign {iface_s, proto_s, chain_s, toggle_s, busy_n_s, load_n_s,
          fs_n_s, sck_s, din_s, scl_s, sda_s, strap_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////
  // state

  logic fs_q_r;
  logic sck_q_r;
  logic load_q_r;
  logic active_r;
  logic [4:0] cnt_r;
  logic [WORD_BITS-1:0] shreg_r;
  logic dout_r;
  logic rb_pend_r;
  logic [WORD_BITS-1:0] rb_word_r;
  logic upd_valid_r;
  logic upd_bank_r;
  logic [CHAN_BITS-1:0] upd_chan_r;
  logic [TGT_BITS-1:0] upd_tgt_r;
  logic [DATA_BITS-1:0] upd_data_r;
  logic load_pulse_r;
  logic bad_frame_r;
  logic bus_data_r;
  logic [DATA_BITS-1:0] regs_r [0:(1<<IDX_BITS)-1];

  // register file index from bank, channel and target
  function automatic logic [IDX_BITS-1:0] reg_index(
    input logic bank,
    input logic [CHAN_BITS-1:0] ch,
    input logic [TGT_BITS-1:0] tg
  );
    reg_index = {bank, ch, tg};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // framed link decode

  wire spi_on = iface_s & ~proto_s & busy_n_s;
  wire tw_on = iface_s & proto_s & busy_n_s;

  // edges of the sampled link pins
  wire fs_fall = fs_q_r & ~fs_n_s;
  wire fs_rise = ~fs_q_r & fs_n_s;
  wire sck_fall = sck_q_r & ~sck_s;
  wire sck_rise = ~sck_q_r & sck_s;
  wire full = (cnt_r == CNT_FULL);

  wire shift_en = spi_on & active_r & sck_fall & (chain_s | ~full);
  // msb first into the low end
  wire [WORD_BITS-1:0] shifted = {shreg_r[WORD_BITS-2:0], din_s};
  wire last_bit = shift_en & ~chain_s & (cnt_r == CNT_FULL - 5'h01);
  wire chain_latch = spi_on & active_r & chain_s & fs_rise & full;
  wire bad = spi_on & active_r & chain_s & fs_rise & ~full;
  wire exec_spi = last_bit | chain_latch;
  wire [WORD_BITS-1:0] exec_word = last_bit ? shifted : shreg_r;

  wire w_rw = exec_word[POS_RW];
  wire [CHAN_BITS-1:0] w_chan = exec_word[POS_CHAN +: CHAN_BITS];
  wire [TGT_BITS-1:0] w_tgt = exec_word[POS_TGT +: TGT_BITS];
  wire [DATA_BITS-1:0] w_data = exec_word[DATA_BITS-1:0];
  // bank honoured only in toggle mode
  wire w_bank = exec_word[POS_BANK] & toggle_s;
  wire spi_wr = exec_spi & ~w_rw & (exec_word != '0); // no-op word skipped
  wire spi_rd = exec_spi & w_rw;

  wire [DATA_BITS-1:0] rd_val = regs_r[reg_index(w_bank, w_chan, w_tgt)];
  wire [WORD_BITS-1:0] rb_next = {exec_word[WORD_BITS-1 -: HDR_BITS], rd_val};
  wire [WORD_BITS-1:0] frame_load = rb_pend_r ? rb_word_r : '0;

  ////////////////////////////////////////////////////////////////////////
  // two-wire slave

  dac_cmd_if tw_cmd ();

  twowire_slave u_tw (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(tw_on),
    .strap_i(strap_s),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .ack_oe_o(bus_data_oe_o),
    .cmd(tw_cmd.src)
  );

  // merge both sources into one write
  wire wr_en = spi_wr | tw_cmd.valid;
  wire wr_bank = spi_wr ? w_bank : tw_cmd.bank;
  wire [CHAN_BITS-1:0] wr_chan = spi_wr ? w_chan : tw_cmd.chan;
  wire [TGT_BITS-1:0] wr_tgt = spi_wr ? w_tgt : tw_cmd.tgt;
  wire [DATA_BITS-1:0] wr_data = spi_wr ? w_data : tw_cmd.data;

  ////////////////////////////////////////////////////////////////////////
  // framed link sequencing

  // edge history of the sampled pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_q_r <= 1'b1;
      sck_q_r <= 1'b1; // shift clock idles high
      load_q_r <= 1'b1;
    end else begin
      fs_q_r <= fs_n_s;
      sck_q_r <= sck_s;
      load_q_r <= load_n_s;
    end
  end

  // frame open flag and bit counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_r <= 1'b0;
      cnt_r <= '0;
    end else if (!spi_on) begin
      active_r <= 1'b0;
    end else if (fs_fall) begin
      active_r <= 1'b1;
      cnt_r <= '0;
    // in standalone, rise ignored until word is in
    end else if (fs_rise && (chain_s || full)) begin
      active_r <= 1'b0;
    end else if (shift_en && !full) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // shift register and chain output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg_r <= '0;
      dout_r <= 1'b0;
    end else if (spi_on && fs_fall) begin
      shreg_r <= frame_load;
      dout_r <= frame_load[WORD_BITS-1];
    end else if (shift_en) begin
      shreg_r <= shifted;
    end else if (spi_on && active_r && sck_rise) begin
      dout_r <= shreg_r[WORD_BITS-1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rb_pend_r <= 1'b0;
      rb_word_r <= '0;
    end else if (spi_rd) begin
      rb_pend_r <= 1'b1;
      rb_word_r <= rb_next;
    end else if (exec_spi) begin // only a good frame consumes it
      rb_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register store and update port

  // channel registers, no reset
  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      regs_r[reg_index(wr_bank, wr_chan, wr_tgt)] <= wr_data;
    end
  end

  // update strobe towards the dac core
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_valid_r <= 1'b0;
      upd_bank_r <= 1'b0;
      upd_chan_r <= '0;
      upd_tgt_r <= '0;
      upd_data_r <= '0;
    end else begin
      upd_valid_r <= wr_en;
      if (wr_en) begin
        upd_bank_r <= wr_bank;
        upd_chan_r <= wr_chan;
        upd_tgt_r <= wr_tgt;
        upd_data_r <= wr_data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_pulse_r <= 1'b0;
      bad_frame_r <= 1'b0;
      bus_data_r <= 1'b0;
    end else begin
      load_pulse_r <= load_q_r & ~load_n_s & busy_n_s;
      bad_frame_r <= bad;
      bus_data_r <= 1'b0;
    end
  end

  // outputs from flops
  assign chain_data_out_o = dout_r;
  assign bus_data_o = bus_data_r;
  assign upd_valid_o = upd_valid_r;
  assign upd_bank_o = upd_bank_r;
  assign upd_channel_address_o = upd_chan_r;
  assign upd_target_o = upd_tgt_r;
  assign upd_data_field_o = upd_data_r;
  assign load_pulse_o = load_pulse_r;
  assign bad_frame_o = bad_frame_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence rd_cmd_s;
    spi_rd;
  endsequence
  sequence rd_armed_s;
    rb_pend_r && !upd_valid_r;
  endsequence
  sequence rd_frame_s;
    spi_on && fs_fall && rb_pend_r;
  endsequence

  chk_frame_restart: assert property (
    spi_on && fs_fall |=> active_r && cnt_r == 5'h00)
    else $error("sync fall did not restart frame");
  chk_std_word_done: assert property (
    spi_on && last_bit && spi_wr |=> upd_valid_o
      && upd_data_field_o == $past(shifted[DATA_BITS-1:0]))
    else $error("standalone word not applied at bit 24");
  chk_std_sck_ignore: assert property (
    spi_on && active_r && !chain_s && full && !fs_fall
      |=> $stable(shreg_r))
    else $error("shift clock not ignored after 24 bits");
  chk_chain_ripple: assert property (
    shift_en && chain_s |=> shreg_r[0] == $past(din_s)
      && shreg_r[WORD_BITS-1] == $past(shreg_r[WORD_BITS-2]))
    else $error("chain shift did not ripple");
  chk_out_edge: assert property (
    !$past(sck_rise) && !$past(spi_on && fs_fall)
      |-> $stable(chain_data_out_o))
    else $error("chain output moved off a rising edge");
  chk_chain_latch: assert property (
    chain_latch |=> !active_r and (!fs_fall [*2] |-> $stable(shreg_r)))
    else $error("chain word not latched on sync rise");
  chk_bad_frame: assert property (
    bad |=> bad_frame_o && !upd_valid_o)
    else $error("bad frame not flagged or applied");
  chk_bad_keep: assert property (
    bad && !tw_cmd.valid |=> $stable(rb_pend_r) && !upd_valid_o)
    else $error("bad frame disturbed readback state");
  chk_read_arm: assert property (
    rd_cmd_s |=> rd_armed_s)
    else $error("read command did not arm readback");
  chk_read_frame: assert property (
    rd_frame_s |=> shreg_r == $past(rb_word_r)
      && chain_data_out_o == $past(rb_word_r[WORD_BITS-1]))
    else $error("first readback bit missing at sync fall");
  chk_read_image: assert property (
    rd_cmd_s |=> rb_word_r[WORD_BITS-1 -: HDR_BITS]
      == $past(exec_word[WORD_BITS-1 -: HDR_BITS]))
    else $error("readback header not echoed");
  chk_busy_block: assert property (
    !busy_n_s |=> !active_r && !load_pulse_o)
    else $error("interface active while busy");
endmodule
`default_nettype wire

// ---- testbench/host_link_model.sv ----
// host model driving the framed link and the two-wire bus
`default_nettype none
module host_link_model (
  // framed link
  output logic fs_n_o,
  output logic sck_o,
  output logic din_o,
  input wire logic dout_i,
  // two-wire bus, open drain with pull-up
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle levels: sync high, sck idles high, bus released
  initial begin
    fs_n_o = 1'b1;
    sck_o = 1'b1;
    din_o = 1'b0;
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one framed transfer, msb first, dout taken at each falling sck
  // exact burst, sync rises after last clock
  task automatic frame(input logic [47:0] w, input int n,
                       output logic [47:0] q);
    q = '0;
    fs_n_o = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = w[i];
      #40 sck_o = 1'b0;
      q = {q[46:0], dout_i};
      #40 sck_o = 1'b1;
    end
    #40 fs_n_o = 1'b1;
    din_o = ~din_o; // released line shows no stale bit
    #80;
  endtask
  // one byte at 400 khz, acknowledge read in the ninth period
  task automatic tw_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      #625 scl_o = 1'b1;
      #1250 scl_o = 1'b0;
      #625;
    end
    sda_o = 1'b1;
    #625 scl_o = 1'b1;
    ack = ~sda_i;
    #1250 scl_o = 1'b0;
    #625;
  endtask
  // start, n bytes, stop; the host owns the clock
  task automatic tw_write(input logic [31:0] b, input int n,
                          output logic [3:0] acks);
    acks = '0;
    sda_o = 1'b0;
    #1250 scl_o = 1'b0;
    #625;
    for (int k = 0; k < n; k++) begin
      tw_byte(b[31-8*k -: 8], acks[3-k]);
    end
    sda_o = 1'b0;
    #625 scl_o = 1'b1;
    #625 sda_o = 1'b1;
    #1250;
  endtask
endmodule
`default_nettype wire

// ---- testbench/dac_serial_host_interface_tb.sv ----
// self-checking bench of the dac serial host interface
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); \
  end end
module dac_serial_host_interface_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dac_host_pkg::*;
  logic clk_i, rst_n_i, sel, proto, chain, tog, busy_n, ld_n, hi, lo;
  logic fs, sck, din, dout, scl, sda_m, sda_w, bdo, oe, uv, ub, ldp, bad;
  logic [4:0] uc;
  logic [1:0] ut;
  logic [13:0] ud;
  logic [21:0] got;
  logic [47:0] q;
  logic [23:0] w, r;
  logic [3:0] acks;
  int n_upd = 0, n_bad = 0, n_ld = 0, n0, n_mismatch = 0, check_count = 0;
  // pull-up wire of the two-wire data line
  assign sda_w = sda_m & ~(oe & ~bdo);
  dac_serial_host_interface dac_serial_host_interface_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .interface_select_pin_i(sel),
    .protocol_select_i(proto), .chain_enable_i(chain),
    .toggle_enable_i(tog), .device_busy_n_i(busy_n),
    .load_strobe_n_i(ld_n), .frame_sync_n_i(fs), .shift_clk_i(sck),
    .data_in_i(din), .chain_data_out_o(dout), .bus_clk_i(scl),
    .bus_data_i(sda_w), .bus_data_o(bdo), .bus_data_oe_o(oe),
    .slave_addr_strap_hi_i(hi), .slave_addr_strap_lo_i(lo),
    .upd_valid_o(uv), .upd_bank_o(ub), .upd_channel_address_o(uc),
    .upd_target_o(ut), .upd_data_field_o(ud), .load_pulse_o(ldp),
    .bad_frame_o(bad));
  host_link_model host_link_model_inst (
    .fs_n_o(fs), .sck_o(sck), .din_o(din), .dout_i(dout),
    .scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // capture of updates and event pulses
  always @(posedge clk_i) begin
    if (uv === 1'b1) begin
      got <= {ub, uc, ut, ud};
      n_upd <= n_upd + 1;
    end
    if (bad === 1'b1) n_bad <= n_bad + 1;
    if (ldp === 1'b1) n_ld <= n_ld + 1;
  end
  // expected update of a framed write word
  function automatic logic [21:0] exp_upd(logic [23:0] x, logic t);
    return {x[23] & t, x[20:14], x[13:0]};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one update expected since count n0, bounded wait
  task automatic chk_upd(logic [21:0] e);
    for (int i = 0; i < 40 && n_upd == n0; i++) @(posedge clk_i);
    if (n_upd == n0) begin
      n_mismatch++;
      end_sim();
    end else begin
      `CHK(n_upd - n0, 1)
      `CHK(got, e)
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_i);
    #1;
  endtask
  initial begin
    {rst_n_i, proto, chain, hi, lo} = '0;
    {sel, tog, busy_n, ld_n} = '1;
    void'($urandom(60));
    repeat (4) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    settle();
    // standalone writes with six surplus clocks, random toggle
    repeat (4) begin
      tog = $urandom;
      w = $urandom;
      w[22] = 1'b0;
      w[23] = w[23] & tog;
      settle();
      n0 = n_upd;
      host_link_model_inst.frame({18'h0, w, 6'h2a}, 30, q);
      chk_upd(exp_upd(w, tog));
    end
    // readback of the last write through a no-operation word
    r = {w[23], 1'b1, 1'b0, w[20:14], 14'h0};
    n0 = n_upd;
    host_link_model_inst.frame({24'h0, r}, 24, q);
    host_link_model_inst.frame('0, 24, q);
    `CHK(n_upd, n0)
    `CHK(q[23:0], {r[23:14], w[13:0]})
    // chain: 48 clocks, the first word leaves on the chain output
    chain = 1'b1;
    r = $urandom;
    w = $urandom;
    w[22] = 1'b0;
    w[23] = w[23] & tog;
    settle();
    n0 = n_upd;
    host_link_model_inst.frame({r, w}, 48, q);
    chk_upd(exp_upd(w, tog));
    `CHK(q[23:0], r)
    // readback survives a short frame in chain mode
    r = {w[23], 1'b1, 1'b0, w[20:14], 14'h0};
    host_link_model_inst.frame({24'h0, r}, 24, q);
    n0 = n_upd;
    host_link_model_inst.frame(48'h3ff, 10, q);
    `CHK(n_bad, 1)
    host_link_model_inst.frame('0, 24, q);
    `CHK(n_upd, n0)
    `CHK(q[23:0], {r[23:14], w[13:0]})
    // busy: frame and load strobe dropped, then strobe taken
    chain = 1'b0;
    busy_n = 1'b0;
    settle();
    host_link_model_inst.frame({24'h0, w}, 24, q);
    repeat (2) begin
      ld_n = 1'b0;
      settle();
      ld_n = 1'b1;
      settle();
      `CHK(n_ld, int'(busy_n))
      busy_n = 1'b1;
      settle();
    end
    `CHK(n_upd, n0)
    // two-wire writes on every strap, then a wrong strap and a read flag
    proto = 1'b1;
    for (int i = 0; i < 6; i++) begin
      {hi, lo} = i[1:0];
      w = $urandom;
      settle();
      n0 = n_upd;
      host_link_model_inst.tw_write({TW_ADDR_FIXED, i[1:0] ^ {i == 4, 1'b0},
        i == 5, 3'h0, w[20:14], w[13:0]}, 4, acks);
      if (i < 4) begin
        `CHK(acks, 4'hf)
        chk_upd({1'b0, w[20:14], w[13:0]});
      end else begin
        `CHK(acks, 4'h0)
        `CHK(n_upd, n0)
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
